// ---- bench/sasf_chk.sv ----
`timescale 1ns/1ps
module sasf_chk (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Analog front end
  input wire logic conv_start,
  input wire logic conv_done,
  input wire logic [63:0] adc_data,
  // External clocks and interrupt
  input wire logic ext_sample_clock_pin,
  input wire logic bus_sample_clock_in,
  input wire logic irq
);
  // ----------------------------------------
  // Port checks
  // ----------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  logic pin_q;
  logic bus_q;
  logic [3:0] since;
  logic cause;
  // Any legal reason to convert
  assign cause = (psel && penable && pwrite && pwdata[0]
    && paddr == sasf_pkg::ADDR_CMD) || ext_sample_clock_pin != pin_q
    || bus_sample_clock_in != bus_q;
  // Saturating age of the last cause, so stray starts show up
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_q <= 1'b0;
      bus_q <= 1'b1;
      since <= 4'hf;
    end else begin
      pin_q <= ext_sample_clock_pin;
      bus_q <= bus_sample_clock_in;
      if (cause) since <= 4'h0;
      else if (since != 4'hf) since <= since + 4'h1;
    end
  end
  sequence conv_quiet;
    !conv_start [*3];
  endsequence
  chk_ready_high: assert property (pready)
    else $error("pready low");
  chk_err_unmapped: assert property (psel && penable && paddr > 8'h14
    |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  chk_mapped_ok: assert property (psel && penable && paddr <= 8'h14
    && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
  chk_err_idle: assert property (!penable |-> !pslverr)
    else $error("pslverr outside access");
  chk_rdata_hold: assert property (!(psel && !penable && !pwrite)
    |=> $stable(prdata))
    else $error("prdata changed without read");
  chk_conv_pulse: assert property (conv_start |=> conv_quiet)
    else $error("conversion restarted too soon");
  chk_conv_cause: assert property (conv_start |-> since <= 4'h5)
    else $error("conversion without cause");
  chk_irq_reset: assert property ($rose(arst_n) |-> !irq)
    else $error("irq high after reset");
endmodule
bind sasf_top sasf_chk chk(.sys_clk, .arst_n, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .conv_start, .conv_done,
  .adc_data, .ext_sample_clock_pin, .bus_sample_clock_in, .irq);

// ---- bench/sasf_fe_model.sv ----
`timescale 1ns/1ps
module sasf_fe_model (
  // Clock
  input wire logic sys_clk,
  // Conversion handshake
  input wire logic conv_start,
  output logic conv_done,
  output logic [63:0] adc_data,
  // Input levels and latency
  input wire logic [63:0] lanes,
  input wire logic [3:0] dly
);
  // ----------------------------------------
  // Simultaneous four-lane converter
  // ----------------------------------------
  logic [63:0] held = 64'h0;
  int cnt = 0;
  initial begin
    conv_done = 1'b0;
    adc_data = 64'h0;
  end
  always @(posedge sys_clk) begin
    conv_done <= 1'b0;
    // Garbage outside done, so stale data never looks valid
    adc_data <= ~adc_data;
    if (conv_start) begin
      held <= lanes;
      cnt <= int'(dly) + 1;
    end else if (cnt == 1) begin
      conv_done <= 1'b1;
      adc_data <= held;
      cnt <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  // ----------------------------------------
  // Stimulus and checking
  // ----------------------------------------
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic pin = 1'b0, bclk = 1'b1;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd, rs = 32'h36;
  logic pready, pslverr, conv_start, conv_done, irq, err;
  logic [63:0] adc_data, lanes = 64'h0;
  logic [3:0] dly = 4'h2;
  logic [31:0] q[$];
  int errors = 0, samples_checked = 0;
  // mux count zero in every setup write
  localparam logic [31:0] LEGAL[7] = '{32'h01, 32'h11, 32'h21, 32'h31,
    32'h42, 32'he2, 32'he44};
  localparam logic [31:0] BAD[3] = '{32'h03, 32'h22, 32'h10e44};
  initial forever #12.5 sys_clk = ~sys_clk;
  sasf_top #(.FIFO_DEPTH(8)) dut(.sys_clk, .arst_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .conv_start,
    .conv_done, .adc_data, .ext_sample_clock_pin(pin),
    .bus_sample_clock_in(bclk), .irq);
  sasf_fe_model fe(.sys_clk, .conv_start, .conv_done, .adc_data, .lanes,
    .dly);
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  // Lane k as read back: low 12 bits sign-extended
  function automatic logic [15:0] ex(int k);
    logic [15:0] v;
    v = lanes[k*16 +: 16];
    return {{4{v[11]}}, v[11:0]};
  endfunction
  task automatic report_and_stop();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic cmp(string n, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic stop_if(logic hit);
    if (hit) begin
      errors++;
      report_and_stop();
    end
  endtask
  // One APB transfer; request held until pready is seen
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge sys_clk);
      if (pready === 1'b1) break;
    end
    stop_if(n == 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wirq(logic [31:0] e);
    int n;
    for (n = 0; n < 300 && irq !== 1'b1; n++) @(posedge sys_clk);
    stop_if(n == 300);
    apb(1'b0, sasf_pkg::ADDR_IRQ_STAT, 32'h0);
    cmp("irq_stat", e, rd);
  endtask
  task automatic rdcmd(logic [31:0] e);
    apb(1'b0, sasf_pkg::ADDR_IRQ_STAT, 32'h0);
    apb(1'b1, sasf_pkg::ADDR_CMD, 32'h1);
    wirq(e);
  endtask
  task automatic chk_words(logic [31:0] c);
    logic [31:0] m;
    m = (c[2:0] == 3'h1) ? 32'hffff : 32'hffffffff;
    apb(1'b0, sasf_pkg::ADDR_DATA, 32'h0);
    cmp("data0", {ex(int'(c[7:6])), ex(int'(c[5:4]))} & m, rd & m);
    if (c[2:0] == 3'h4) begin
      apb(1'b0, sasf_pkg::ADDR_DATA, 32'h0);
      cmp("data1", {ex(3), ex(2)}, rd);
    end
  endtask
  // One external sample edge, pin rise or bus-clock fall
  task automatic smp(logic on_bus);
    int n;
    lanes <= {rnd(), rnd()};
    @(posedge sys_clk);
    if (on_bus) bclk <= 1'b0;
    else pin <= 1'b1;
    for (n = 0; n < 40 && conv_done !== 1'b1; n++) @(posedge sys_clk);
    stop_if(n == 40);
    repeat (3) @(posedge sys_clk);
    pin <= 1'b0;
    bclk <= 1'b1;
    @(posedge sys_clk);
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    apb(1'b0, sasf_pkg::ADDR_CONFIG, 32'h0);
    cmp("config", 32'he44, rd);
    apb(1'b0, 8'h18, 32'h0);
    cmp("unmapped", 32'h0, rd | {31'h0, !err});
    apb(1'b1, sasf_pkg::ADDR_IRQ_MASK, 32'hf);
    foreach (LEGAL[i]) begin
      apb(1'b1, sasf_pkg::ADDR_CONFIG, LEGAL[i]);
      lanes <= {rnd(), rnd()};
      dly <= 4'(rnd() & 32'h7);
      rdcmd(32'h1);
      chk_words(LEGAL[i]);
    end
    foreach (BAD[i]) begin
      apb(1'b1, sasf_pkg::ADDR_CONFIG, BAD[i]);
      wirq(32'h8);
      apb(1'b0, sasf_pkg::ADDR_CONFIG, 32'h0);
      cmp("config", 32'he44, rd);
    end
    apb(1'b1, sasf_pkg::ADDR_IRQ_MASK, 32'h0);
    apb(1'b1, sasf_pkg::ADDR_CONFIG, 32'h03);
    cmp("irq_masked", 32'h0, {31'h0, irq});
    apb(1'b1, sasf_pkg::ADDR_IRQ_MASK, 32'hf);
    wirq(32'h8);
    apb(1'b1, sasf_pkg::ADDR_CONFIG, 32'h42);
    apb(1'b1, sasf_pkg::ADDR_CMD, 32'h4);
    rdcmd(32'h2);
    for (int k = 0; k < 2; k++) begin
      smp(k[0]);
      q.push_back({ex(1), ex(0)});
    end
    for (int k = 0; k < 2; k++) begin
      rdcmd(32'h1);
      apb(1'b0, sasf_pkg::ADDR_DATA, 32'h0);
      cmp("fifo", q.pop_front(), rd);
    end
    apb(1'b1, sasf_pkg::ADDR_CONFIG, 32'h21);
    apb(1'b1, sasf_pkg::ADDR_CMD, 32'h4);
    smp(1'b0);
    q.push_back({16'h0, ex(2)});
    smp(1'b1);
    rdcmd(32'h1);
    apb(1'b0, sasf_pkg::ADDR_DATA, 32'h0);
    cmp("pair", {ex(2), 16'h0} | q.pop_front(), rd);
    apb(1'b1, sasf_pkg::ADDR_CONFIG, 32'h42);
    apb(1'b1, sasf_pkg::ADDR_CMD, 32'h4);
    repeat (9) smp(1'b0);
    apb(1'b0, sasf_pkg::ADDR_STATUS, 32'h0);
    cmp("ovf", 32'h8, rd & 32'hc);
    apb(1'b1, sasf_pkg::ADDR_CMD, 32'h2);
    apb(1'b0, sasf_pkg::ADDR_STATUS, 32'h0);
    cmp("cleared", 32'h6, rd & 32'h1e);
    apb(1'b1, sasf_pkg::ADDR_CMD, 32'hc);
    apb(1'b0, sasf_pkg::ADDR_STATUS, 32'h0);
    cmp("disarmed", 32'h0, rd & 32'h2);
    rdcmd(32'h1);
    chk_words(32'h42);
    report_and_stop();
  end
endmodule

// ---- logic/sasf_fifo.sv ----
`timescale 1ns/1ps
module sasf_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Control
  input wire logic flush,
  // Write side
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [WIDTH-1:0] wr_data,
  // Read side
  input wire logic rd_pop,
  output logic rd_valid,
  output logic [WIDTH-1:0] rd_data
);

  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
      $error("sasf_fifo: DEPTH must be a power of two >= 2");
    end
  end

  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } sasf_fifo_st_t;

  sasf_fifo_st_t st;
  sasf_fifo_st_t next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic do_wr;
  logic do_rd;

  // Full when pointers differ only in the wrap bit
  assign wr_ready = (st.wp ^ st.rp) != {1'b1, {AW{1'b0}}};
  assign rd_valid = st.wp != st.rp;
  assign do_wr = wr_valid && wr_ready && !flush;
  assign do_rd = rd_pop && rd_valid && !flush;
  assign rd_data = mem[st.rp[AW-1:0]];

  // Pointer update; flush wins over traffic
  always_comb begin
    next_st = st;
    if (flush) begin
      next_st.wp = '0;
      next_st.rp = '0;
    end else begin
      if (do_wr) next_st.wp = st.wp + 1'b1;
      if (do_rd) next_st.rp = st.rp + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Storage has no reset, data only
  always_ff @(posedge sys_clk) begin
    if (do_wr) begin
      mem[st.wp[AW-1:0]] <= wr_data;
    end
  end

endmodule

// ---- logic/sasf_pkg.sv ----
package sasf_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_CMD = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_DATA = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;

  // ----------------------------------------------------------------
  // Config fields
  // ----------------------------------------------------------------
  localparam int CFG_CNT_LSB = 0;
  localparam int CFG_CH0_LSB = 4;
  localparam int CFG_CH1_LSB = 6;
  localparam int CFG_CH2_LSB = 8;
  localparam int CFG_CH3_LSB = 10;
  localparam int CFG_IVL_LSB = 16;
  localparam int CFG_MUX_LSB = 24;

  // ----------------------------------------------------------------
  // Command bits
  // ----------------------------------------------------------------
  localparam int CMD_READ = 0;
  localparam int CMD_CLEAR = 1;
  localparam int CMD_ARM = 2;
  localparam int CMD_ARM_MODE = 3;

  // ----------------------------------------------------------------
  // Status and interrupt bits
  // ----------------------------------------------------------------
  localparam int ST_BUSY = 0;
  localparam int ST_ARMED = 1;
  localparam int ST_EMPTY = 2;
  localparam int ST_OVF = 3;
  localparam int ST_ERR = 4;
  localparam int ST_CFG_BAD = 5;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_EMPTY = 1;
  localparam int IRQ_OVF = 2;
  localparam int IRQ_CFG = 3;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [2:0] RST_CNT4 = 3'h4;
  localparam logic [2:0] RST_CNT2 = 3'h2;
  localparam int CONV_CYCLES = 4;
  localparam logic ARM_ENABLE = 1'b0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONV = 3'b010,
    ST_LOAD = 3'b100
  } sasf_state_t;

endpackage

// ---- logic/sasf_top.sv ----
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
// Function
// - Each read yields exactly scan_channel_count values, except an armed single-channel read, which yields a pair.
// - 12-bit variant returns sign-extended two's complement readings.
// - 16-bit variants return signed 16-bit readings.
// - Unarmed read samples all scanned channels immediately.
// - Armed read pops oldest stored sample set, FIFO order.
// - Armed read with empty FIFO flags error, no data.
// - Clear command empties FIFO and clears overflow, any time; an overflow first raised in the clear's own cycle stays set.
// - Single-channel external mode stores pairs, earlier sample first.
// - Channel count 1,2,4 (four inputs) or 1,2 (two inputs).
// - Four-input lists: single, 0-1, 2-3, or 0-1-2-3.
// - Two-input lists: single, 0-1 or 1-0.
// - Gain fixed at unity; gain settings ignored.
// - All channels sampled together; interval must be zero.
// - Scan list defaults to all input channels after reset.
// - Arm flushes FIFO; sample on pin rise or bus-clock fall.
// - Arm mode 0 enables external conversion, 1 disables.
module sasf_top #(
  parameter int NUM_INPUTS = 4,
  parameter int ADC_BITS = 12,
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog front end
  output logic conv_start,
  input wire logic conv_done,
  input wire logic [4*16-1:0] adc_data,
  // External clocks
  input wire logic ext_sample_clock_pin,
  input wire logic bus_sample_clock_in,
  // Interrupt
  output logic irq
);

  initial begin
    if (NUM_INPUTS != 2 && NUM_INPUTS != 4) begin
      $error("sasf_top: NUM_INPUTS must be 2 or 4");
    end
    if (ADC_BITS != 12 && ADC_BITS != 16) begin
      $error("sasf_top: ADC_BITS must be 12 or 16");
    end
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    sasf_pkg::sasf_state_t fsm;
    logic [2:0] cnt;
    logic [7:0] chsel;
    logic armed;
    logic err;
    logic ovf;
    logic cfg_bad;
    logic ext_run;
    logic half;
    logic [15:0] held;
    logic [63:0] smp;
    logic [63:0] res;
    logic [2:0] rd_idx;
    logic [3:0] istat;
    logic [3:0] imask;
    logic pin_d;
    logic bus_d;
    logic conv_start;
  } sasf_st_t;

  sasf_st_t st;
  sasf_st_t next_st;

  logic wr_acc;
  logic rd_acc;
  logic ext_edge;
  logic fifo_flush;
  logic fifo_push;
  logic fifo_ready;
  logic fifo_valid;
  logic fifo_pop;
  logic [63:0] fifo_dout;
  logic [63:0] fifo_din;
  logic [63:0] sample_set;
  logic [15:0] ch_word [4];
  logic [31:0] rd_mux;
  logic cfg_ok;
  logic [2:0] w_cnt;
  logic [7:0] w_ch;

  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign w_cnt = pwdata[sasf_pkg::CFG_CNT_LSB +: 3];
  assign w_ch = pwdata[sasf_pkg::CFG_CH0_LSB +: 8];

  // Per-input widening to a signed 16-bit word
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_ch
      if (ADC_BITS == 12) begin : g_12
        assign ch_word[gi] = {{4{adc_data[gi*16+11]}},
                              adc_data[gi*16 +: 12]};
      end else begin : g_16
        assign ch_word[gi] = adc_data[gi*16 +: 16];
      end
    end
  endgenerate

  // Pack scan list in order; unity gain, no scaling path
  // gain fixed
  always_comb begin
    sample_set = '0;
    for (int k = 0; k < 4; k++) begin
      if (3'(k) < st.cnt) begin
        sample_set[k*16 +: 16] = ch_word[st.chsel[k*2 +: 2]];
      end
    end
  end

  // Validate a scan setup write
  // count check
  always_comb begin
    cfg_ok = 1'b0;
    if (NUM_INPUTS == 4) begin
      if (w_cnt == 3'h1) cfg_ok = 1'b1;
      else if (w_cnt == 3'h2) begin
        cfg_ok = (w_ch[3:0] == 4'h4) || (w_ch[3:0] == 4'he);
      end else if (w_cnt == 3'h4) cfg_ok = (w_ch == 8'he4);
    end else begin
      if (w_cnt == 3'h1) cfg_ok = !w_ch[1];
      else if (w_cnt == 3'h2) begin
        cfg_ok = (w_ch[3:0] == 4'h4) || (w_ch[3:0] == 4'h1);
      end
    end
    if (pwdata[sasf_pkg::CFG_IVL_LSB +: 8] != 8'h00) cfg_ok = 1'b0;
  end

  // External edge: pin rising or bus clock falling
  // edge select
  assign ext_edge = st.ext_run &&
    ((ext_sample_clock_pin && !st.pin_d) ||
     (!bus_sample_clock_in && st.bus_d));

  assign fifo_flush = wr_acc && paddr == sasf_pkg::ADDR_CMD &&
    (pwdata[sasf_pkg::CMD_CLEAR] || pwdata[sasf_pkg::CMD_ARM]);
  assign fifo_din = (st.cnt == 3'h1) ?
    {32'h0, st.smp[15:0], st.held} : st.smp;
  assign fifo_push = st.fsm == sasf_pkg::ST_LOAD && st.armed &&
    (st.cnt != 3'h1 || st.half) && !fifo_flush;
  assign fifo_pop = st.fsm == sasf_pkg::ST_IDLE && st.armed && !ext_edge &&
    wr_acc && paddr == sasf_pkg::ADDR_CMD &&
    pwdata[sasf_pkg::CMD_READ] && !fifo_flush;

  sasf_fifo #(.WIDTH(64), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .flush(fifo_flush),
    .wr_valid(fifo_push),
    .wr_ready(fifo_ready),
    .wr_data(fifo_din),
    .rd_pop(fifo_pop),
    .rd_valid(fifo_valid),
    .rd_data(fifo_dout)
  );

  // Main next-state logic
  always_comb begin
    next_st = st;
    next_st.pin_d = ext_sample_clock_pin;
    next_st.bus_d = bus_sample_clock_in;
    next_st.conv_start = 1'b0;
    // Result words walk on each data read; a new result restarts them
    if (rd_acc && paddr == sasf_pkg::ADDR_DATA) begin
      next_st.rd_idx = st.rd_idx + 3'h1;
    end
    case (st.fsm)
      sasf_pkg::ST_IDLE: begin
        if (ext_edge) begin
          next_st.conv_start = 1'b1;
          next_st.fsm = sasf_pkg::ST_CONV;
        end
      end
      sasf_pkg::ST_CONV: begin
        if (conv_done) begin
          // Lanes are valid only while done is high
          next_st.smp = sample_set;
          next_st.fsm = sasf_pkg::ST_LOAD;
        end
      end
      sasf_pkg::ST_LOAD: begin
        next_st.fsm = sasf_pkg::ST_IDLE;
        if (st.armed) begin
          if (st.cnt == 3'h1 && !st.half) begin
            next_st.held = st.smp[15:0];
            next_st.half = 1'b1;
          end else if (!fifo_ready) begin
            next_st.ovf = 1'b1;
            next_st.istat[sasf_pkg::IRQ_OVF] = 1'b1;
            next_st.half = 1'b0;
          end else begin
            next_st.half = 1'b0;
          end
        end else begin
          next_st.res = st.smp;
          next_st.rd_idx = '0;
          next_st.istat[sasf_pkg::IRQ_DONE] = 1'b1;
        end
      end
      default: next_st.fsm = sasf_pkg::ST_IDLE;
    endcase
    // Read clears only bits shown at setup; later sets survive
    if (rd_acc && paddr == sasf_pkg::ADDR_IRQ_STAT) begin
      next_st.istat = st.istat & ~prdata[3:0];
      if (st.fsm == sasf_pkg::ST_LOAD) begin
        next_st.istat[sasf_pkg::IRQ_DONE] |= !st.armed;
        next_st.istat[sasf_pkg::IRQ_OVF] |= st.armed && !fifo_ready &&
          (st.cnt != 3'h1 || st.half);
      end
    end
    if (wr_acc && paddr == sasf_pkg::ADDR_CONFIG) begin
      if (cfg_ok) begin
        next_st.cnt = w_cnt;
        next_st.chsel = w_ch;
        next_st.cfg_bad = 1'b0;
        next_st.half = 1'b0;
      end else begin
        next_st.cfg_bad = 1'b1;
        next_st.istat[sasf_pkg::IRQ_CFG] = 1'b1;
      end
    end
    if (wr_acc && paddr == sasf_pkg::ADDR_IRQ_MASK) begin
      next_st.imask = pwdata[3:0];
    end
    if (wr_acc && paddr == sasf_pkg::ADDR_CMD) begin
      if (pwdata[sasf_pkg::CMD_CLEAR]) begin
        next_st.ovf = next_st.ovf && !st.ovf;
        next_st.err = 1'b0;
        next_st.half = 1'b0;
      end
      if (pwdata[sasf_pkg::CMD_ARM]) begin
        next_st.armed = pwdata[sasf_pkg::CMD_ARM_MODE] ==
          sasf_pkg::ARM_ENABLE;
        next_st.ext_run = next_st.armed;
        next_st.half = 1'b0;
      end else if (pwdata[sasf_pkg::CMD_READ] &&
                   st.fsm == sasf_pkg::ST_IDLE && !ext_edge) begin
        if (!st.armed) begin
          next_st.conv_start = 1'b1;
          next_st.fsm = sasf_pkg::ST_CONV;
          next_st.err = 1'b0;
        end else if (fifo_valid && !pwdata[sasf_pkg::CMD_CLEAR]) begin
          next_st.res = fifo_dout;
          next_st.rd_idx = '0;
          next_st.err = 1'b0;
          next_st.istat[sasf_pkg::IRQ_DONE] = 1'b1;
        end else begin
          next_st.err = 1'b1;
          next_st.istat[sasf_pkg::IRQ_EMPTY] = 1'b1;
        end
      end
    end
  end

  // Read mux; data register returns two readings per word
  always_comb begin
    rd_mux = 32'h0;
    if (paddr == sasf_pkg::ADDR_CONFIG) begin
      rd_mux = {24'h0, st.chsel[3:0], 1'b0, st.cnt};
      rd_mux[sasf_pkg::CFG_CH2_LSB +: 4] = st.chsel[7:4];
    end else if (paddr == sasf_pkg::ADDR_STATUS) begin
      rd_mux[sasf_pkg::ST_BUSY] = st.fsm != sasf_pkg::ST_IDLE;
      rd_mux[sasf_pkg::ST_ARMED] = st.armed;
      rd_mux[sasf_pkg::ST_EMPTY] = !fifo_valid;
      rd_mux[sasf_pkg::ST_OVF] = st.ovf;
      rd_mux[sasf_pkg::ST_ERR] = st.err;
      rd_mux[sasf_pkg::ST_CFG_BAD] = st.cfg_bad;
    end else if (paddr == sasf_pkg::ADDR_DATA) begin
      rd_mux = st.rd_idx[0] ? st.res[63:32] : st.res[31:0];
    end else if (paddr == sasf_pkg::ADDR_IRQ_STAT) begin
      rd_mux = {28'h0, st.istat};
    end else if (paddr == sasf_pkg::ADDR_IRQ_MASK) begin
      rd_mux = {28'h0, st.imask};
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
      st.fsm <= sasf_pkg::ST_IDLE;
      st.cnt <= (NUM_INPUTS == 4) ? sasf_pkg::RST_CNT4 :
                sasf_pkg::RST_CNT2;
      st.chsel <= (NUM_INPUTS == 4) ? 8'he4 : 8'h04;
      st.pin_d <= 1'b0;
      st.bus_d <= 1'b1;
      prdata <= 32'h0;
    end else begin
      st <= next_st;
      if (psel && !penable && !pwrite) prdata <= rd_mux;
    end
  end

  // Setup cycle latches read data, so access completes at once
  assign pready = 1'b1;
  assign pslverr = psel && penable && !(paddr == sasf_pkg::ADDR_CONFIG ||
    paddr == sasf_pkg::ADDR_CMD || paddr == sasf_pkg::ADDR_STATUS ||
    paddr == sasf_pkg::ADDR_DATA || paddr == sasf_pkg::ADDR_IRQ_STAT ||
    paddr == sasf_pkg::ADDR_IRQ_MASK);
  assign conv_start = st.conv_start;
  assign irq = |(st.istat & st.imask);

endmodule
